// file: core/disk_port_consts.vh
// Purpose: Constants of the drive status and data port
// Assumes: 250 MHz system clock
// Notes: Offsets are byte addresses on the register bus
`ifndef DISK_PORT_CONSTS_VH
`define DISK_PORT_CONSTS_VH
// ***********************************
// Timing
// ***********************************
`define MCLK_PERIOD_NS 4
`define INDEX_PERIOD_US 16700
`define ATTN_LEAD_NS 100
`define INDEX_WIDTH_NS 1000
`define WORD_BITS 16
// ***********************************
// Register offsets
// ***********************************
`define OFF_GENCFG 8'h00
`define OFF_FIXCYL 8'h04
`define OFF_HEADS 8'h08
`define OFF_TRKBYTES 8'h0C
`define OFF_SECBYTES 8'h10
`define OFF_SECTORS 8'h14
`define OFF_GAP 8'h18
`define OFF_SYNC 8'h1C
`define OFF_VENDOR 8'h20
`define OFF_CTRL 8'h24
`define OFF_FAULT 8'h28
`define OFF_SECLEN 8'h2C
`define OFF_STATUS 8'h30
// ***********************************
// Commands and modifiers
// ***********************************
`define OP_STATUS 4'h2
`define OP_CONFIG 4'h3
`define MOD_GENERAL 4'h0
`define MOD_FIXCYL 4'h1
`define MOD_REMCYL 4'h2
`define MOD_HEADS 4'h3
`define MOD_TRKBYTES 4'h4
`define MOD_SECBYTES 4'h5
`define MOD_SECTORS 4'h6
`define MOD_GAP 4'h7
`define MOD_SYNC 4'h8
`define MOD_VENDOR 4'h9
// ***********************************
// Status bit positions
// ***********************************
`define ST_REM_ABSENT 14
`define ST_REM_WP 13
`define ST_FIX_WP 12
`define ST_SPIN_STOP 9
`define ST_POR 8
`define ST_WFAULT 1
`define ST_ATTN_TOP 11
// Software settable fault bits 7,6,5,4,3,2,0
`define FAULT_SW_MASK 16'h00FD
`define CTRL_STOP 0
`define CTRL_PORDONE 1
`endif

// file: core/disk_status_config_data_port.v
// Purpose: Drive side of the status, config and NRZ data port
// Assumes: Command decoding lives outside and hands over opcodes
// Notes: Link pins pass two flip-flops before use
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "disk_port_consts.vh"
module disk_status_config_data_port #(
   parameter INDEX_CYCLES =
      `INDEX_PERIOD_US * 1000 / `MCLK_PERIOD_NS,
   parameter REF_HALF = 4'h5
) (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Command decoder side
   input wire cmdFirstBit,
   input wire cmdRequest,
   input wire [3:0] cmdOpcode,
   input wire [3:0] cmdModifier,
   input wire cmdFinish,
   input wire resetAttention,
   input wire driveSelected,
   input wire headsOffTrackZero,
   // Drive condition inputs
   input wire remMediaAbsent,
   input wire remWriteProtect,
   input wire fixWriteProtect,
   input wire headSelectOk,
   input wire plLocked,
   input wire sectoringOptionJumper,
   input wire addrMarkDetect,
   // Link pins from the host or read channel
   input wire xferReq,
   input wire writeGate,
   input wire readGate,
   input wire writeClk,
   input wire writeDataIn,
   input wire recoveredClk,
   input wire rawReadData,
   input wire writeCurrentSense,
   // Link pins to the host
   output reg xferAck,
   output reg configStatusData,
   output reg attention,
   output reg cmdComplete,
   output reg indexGatedN,
   output reg indexN,
   output reg sectorGated,
   output reg sectorOut,
   output reg readRefClk,
   output reg readData,
   // Write channel side
   output reg writeBit,
   output reg writeStrobe,
   output reg writeInhibit
);
   // ***********************************
   // Derived counts
   // ***********************************
   localparam ATTN_LEAD = (`ATTN_LEAD_NS + `MCLK_PERIOD_NS - 1)
      / `MCLK_PERIOD_NS;
   localparam INDEX_W = `INDEX_WIDTH_NS / `MCLK_PERIOD_NS;
   localparam S_IDLE = 2'b00;
   localparam S_BIT = 2'b01;
   localparam S_HOLD = 2'b10;

   // ***********************************
   // Pin synchronisers
   // ***********************************
   reg [7:0] pinMeta_q; // First stage, read only by second
   reg [7:0] pinSync_q; // Safe copies
   // Two flops per pin
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pinMeta_q <= 8'h00;
         pinSync_q <= 8'h00;
      end else begin
         pinMeta_q <= {writeCurrentSense, rawReadData, recoveredClk,
            writeDataIn, writeClk, writeGate, readGate, xferReq};
         pinSync_q <= pinMeta_q;
      end
   end
   wire reqS = pinSync_q[0];
   wire rdGateS = pinSync_q[1];
   wire wrGateS = pinSync_q[2];
   wire wrClkS = pinSync_q[3];
   wire wrDataS = pinSync_q[4];
   wire recClkS = pinSync_q[5];
   wire rdDataS = pinSync_q[6];
   wire wrCurS = pinSync_q[7];

   // ***********************************
   // Register file
   // ***********************************
   reg [15:0] genCfg_q, fixCyl_q, heads_q, trkBytes_q, secBytes_q;
   reg [7:0] sectors_q, sync_q;
   reg [15:0] gap_q;
   reg [3:0] vendor_q;
   reg [1:0] ctrl_q; // Stop spindle, power-on done
   reg [15:0] fault_q; // Sticky fault bits
   reg [31:0] secLen_q; // Sector length in clocks, 0 off
   reg [15:0] status; // Live status word
   wire apbWr = psel & penable & pwrite & ~pready;
   wire apbRd = psel & penable & ~pwrite & ~pready;
   reg wFault; // Write fault condition now
   reg [31:0] rdMux;
   reg badAddr;

   always @* begin
      wFault = (wrCurS & ~wrGateS)
         | (~wrCurS & wrGateS & driveSelected)
         | (wrGateS & ~headSelectOk)
         | (wrGateS & fixWriteProtect)
         | (rdGateS & wrGateS);
   end

   // Status word assembly, reserved bits read zero
   always @* begin
      status = fault_q & `FAULT_SW_MASK;
      status[`ST_REM_ABSENT] = remMediaAbsent;
      status[`ST_REM_WP] = remWriteProtect;
      status[`ST_FIX_WP] = fixWriteProtect;
      status[`ST_SPIN_STOP] = ctrl_q[`CTRL_STOP]
         | ~ctrl_q[`CTRL_PORDONE];
      status[`ST_POR] = ~ctrl_q[`CTRL_PORDONE];
      status[`ST_WFAULT] = fault_q[`ST_WFAULT];
   end

   // Read decode, unmapped answers error
   always @* begin
      rdMux = 32'h0000_0000;
      badAddr = 1'b0;
      if (paddr == `OFF_GENCFG) begin
         rdMux[15:0] = genCfg_q;
      end else if (paddr == `OFF_FIXCYL) begin
         rdMux[15:0] = fixCyl_q;
      end else if (paddr == `OFF_HEADS) begin
         rdMux[15:0] = heads_q;
      end else if (paddr == `OFF_TRKBYTES) begin
         rdMux[15:0] = trkBytes_q;
      end else if (paddr == `OFF_SECBYTES) begin
         rdMux[15:0] = secBytes_q;
      end else if (paddr == `OFF_SECTORS) begin
         rdMux[7:0] = sectors_q;
      end else if (paddr == `OFF_GAP) begin
         rdMux[15:0] = gap_q;
      end else if (paddr == `OFF_SYNC) begin
         rdMux[7:0] = sync_q;
      end else if (paddr == `OFF_VENDOR) begin
         rdMux[3:0] = vendor_q;
      end else if (paddr == `OFF_CTRL) begin
         rdMux[1:0] = ctrl_q;
      end else if (paddr == `OFF_FAULT) begin
         rdMux[15:0] = fault_q;
      end else if (paddr == `OFF_SECLEN) begin
         rdMux = secLen_q;
      end else if (paddr == `OFF_STATUS) begin
         rdMux[15:0] = status;
      end else begin
         badAddr = 1'b1;
      end
   end

   // Bus answer one cycle into the access phase
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & badAddr;
         prdata <= apbRd ? rdMux : 32'h0000_0000;
      end
   end

   // Register writes; status register is read only
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         genCfg_q <= 16'h0000;
         fixCyl_q <= 16'h0000;
         heads_q <= 16'h0000;
         trkBytes_q <= 16'h0000;
         secBytes_q <= 16'h0000;
         sectors_q <= 8'h00;
         gap_q <= 16'h0000;
         sync_q <= 8'h00;
         vendor_q <= 4'h0;
         ctrl_q <= 2'b00;
         secLen_q <= 32'h0000_0000;
      end else if (apbWr) begin
         if (paddr == `OFF_GENCFG) genCfg_q <= pwdata[15:0];
         else if (paddr == `OFF_FIXCYL) fixCyl_q <= pwdata[15:0];
         else if (paddr == `OFF_HEADS) heads_q <= pwdata[15:0];
         else if (paddr == `OFF_TRKBYTES) trkBytes_q <= pwdata[15:0];
         else if (paddr == `OFF_SECBYTES) secBytes_q <= pwdata[15:0];
         else if (paddr == `OFF_SECTORS) sectors_q <= pwdata[7:0];
         else if (paddr == `OFF_GAP) gap_q <= pwdata[15:0];
         else if (paddr == `OFF_SYNC) sync_q <= pwdata[7:0];
         else if (paddr == `OFF_VENDOR) vendor_q <= pwdata[3:0];
         else if (paddr == `OFF_CTRL) ctrl_q <= pwdata[1:0];
         else if (paddr == `OFF_SECLEN) secLen_q <= pwdata;
      end
   end

   // Sticky faults: set wins over attention reset
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_q <= 16'h0000;
      end else begin
         fault_q <= (resetAttention ? 16'h0000 : fault_q)
            | ((apbWr && paddr == `OFF_FAULT) ?
               (pwdata[15:0] & `FAULT_SW_MASK) : 16'h0000)
            | (wFault ? (16'h0001 << `ST_WFAULT) : 16'h0000);
      end
   end

   // ***********************************
   // Attention and command complete
   // ***********************************
   reg [11:0] lowPrev_q; // Last attention bits 11:0 of status
   reg [7:0] attnAge_q; // Cycles attention has stood
   reg donePending_q;
   reg porSeen_q; // Power-on check done
   reg xferDone; // From shifter below
   wire [11:0] lowNow = status[`ST_ATTN_TOP:0];
   wire attnRise = |(lowNow & ~lowPrev_q);
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         lowPrev_q <= 12'h000;
         attention <= 1'b0;
         attnAge_q <= 8'h00;
         writeInhibit <= 1'b0;
      end else begin
         lowPrev_q <= lowNow;
         if (attnRise) attention <= 1'b1;
         else if (resetAttention) attention <= 1'b0;
         if (!attention) attnAge_q <= 8'h00;
         else if (attnAge_q != 8'hFF) attnAge_q <= attnAge_q + 8'h01;
         writeInhibit <= attention | attnRise;
      end
   end

   // Completion waits out the attention lead
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cmdComplete <= 1'b0;
         donePending_q <= 1'b0;
         porSeen_q <= 1'b0;
      end else begin
         porSeen_q <= 1'b1;
         // Drop on first bit, or at power-on while heads are off track zero
         if (cmdFirstBit || (!porSeen_q && headsOffTrackZero)) begin
            cmdComplete <= 1'b0;
            donePending_q <= 1'b0;
         end else if (!porSeen_q) begin
            cmdComplete <= 1'b1;
         end else if (cmdFinish || xferDone) begin
            donePending_q <= 1'b1;
         end else if (donePending_q && !attnRise && (!attention
               || attnAge_q >= ATTN_LEAD[7:0])) begin
            cmdComplete <= 1'b1;
            donePending_q <= 1'b0;
         end
      end
   end

   // ***********************************
   // Serial word shifter
   // ***********************************
   reg [1:0] st_q;
   reg [16:0] shift_q; // Word then parity
   reg [4:0] bitsLeft_q;
   reg [15:0] word;
   // Configuration and status word select
   always @* begin
      word = 16'h0000;
      if (cmdOpcode == `OP_STATUS) begin
         word = status;
      end else begin
         case (cmdModifier)
            `MOD_GENERAL: word = genCfg_q;
            `MOD_FIXCYL: word = fixCyl_q;
            `MOD_REMCYL: word = 16'h0000;
            `MOD_HEADS: word = heads_q;
            `MOD_TRKBYTES: word = trkBytes_q;
            `MOD_SECBYTES: word = secBytes_q;
            `MOD_SECTORS: word = {8'h00, sectors_q};
            `MOD_GAP: word = gap_q;
            `MOD_SYNC: word = {8'h00, sync_q};
            `MOD_VENDOR: word = {12'h000, vendor_q};
            default: word = 16'h0000;
         endcase
      end
   end

   // Interlocked bit transfer
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= S_IDLE;
         shift_q <= 17'h00000;
         bitsLeft_q <= 5'h00;
         xferAck <= 1'b0;
         configStatusData <= 1'b0;
         xferDone <= 1'b0;
      end else begin
         xferDone <= 1'b0;
         case (st_q)
            S_IDLE: begin
               if (cmdRequest && (cmdOpcode == `OP_STATUS
                     || cmdOpcode == `OP_CONFIG)) begin
                  shift_q <= {word, ~^word};
                  bitsLeft_q <= 5'h11;
                  st_q <= S_BIT;
               end
            end
            S_BIT: begin
               if (reqS) begin
                  configStatusData <= shift_q[16];
                  xferAck <= 1'b1;
                  st_q <= S_HOLD;
               end
            end
            S_HOLD: begin
               if (!reqS) begin
                  xferAck <= 1'b0;
                  shift_q <= {shift_q[15:0], 1'b0};
                  bitsLeft_q <= bitsLeft_q - 5'h01;
                  if (bitsLeft_q == 5'h01) begin
                     st_q <= S_IDLE;
                     xferDone <= 1'b1;
                  end else begin
                     st_q <= S_BIT;
                  end
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // ***********************************
   // Index and sector timing
   // ***********************************
   reg [31:0] revCnt_q; // Position in revolution
   reg [31:0] secCnt_q; // Position in sector
   reg [15:0] pulseCnt_q; // Remaining pulse width
   reg [15:0] secPulse_q;
   wire revWrap = (revCnt_q == INDEX_CYCLES - 1);
   // Sector pulse only if a whole sector still fits
   wire secFits = (INDEX_CYCLES - revCnt_q) > secLen_q;
   wire secStart = (secLen_q != 32'h0000_0000) && secFits
      && (secCnt_q == secLen_q - 32'h0000_0001);
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         revCnt_q <= 32'h0000_0000;
         secCnt_q <= 32'h0000_0000;
         pulseCnt_q <= 16'h0000;
         secPulse_q <= 16'h0000;
         indexN <= 1'b1;
         indexGatedN <= 1'b1;
         sectorOut <= 1'b0;
         sectorGated <= 1'b0;
      end else begin
         revCnt_q <= revWrap ? 32'h0000_0000 : revCnt_q + 32'h1;
         if (revWrap || secStart) secCnt_q <= 32'h0000_0000;
         else secCnt_q <= secCnt_q + 32'h0000_0001;
         if (revWrap) pulseCnt_q <= INDEX_W[15:0];
         else if (pulseCnt_q != 16'h0000)
            pulseCnt_q <= pulseCnt_q - 16'h0001;
         if (revWrap || secStart) secPulse_q <= INDEX_W[15:0];
         else if (secPulse_q != 16'h0000)
            secPulse_q <= secPulse_q - 16'h0001;
         indexN <= (pulseCnt_q == 16'h0000);
         indexGatedN <= (pulseCnt_q == 16'h0000) | ~driveSelected;
         if (sectoringOptionJumper) begin
            sectorOut <= addrMarkDetect;
            sectorGated <= addrMarkDetect & driveSelected;
         end else begin
            sectorOut <= (secPulse_q != 16'h0000);
            sectorGated <= (secPulse_q != 16'h0000) & driveSelected;
         end
      end
   end

   // ***********************************
   // Read and write data path
   // ***********************************
   reg [3:0] refDiv_q;
   reg refClk_q;
   reg useRead_q; // Read clock selected
   reg prevWrClk_q;
   wire wantRead = rdGateS & plLocked;
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         refDiv_q <= 4'h0;
         refClk_q <= 1'b0;
         useRead_q <= 1'b0;
         readRefClk <= 1'b0;
         readData <= 1'b0;
         prevWrClk_q <= 1'b0;
         writeBit <= 1'b0;
         writeStrobe <= 1'b0;
      end else begin
         if (refDiv_q == REF_HALF - 4'h1) begin
            refDiv_q <= 4'h0;
            refClk_q <= ~refClk_q;
         end else begin
            refDiv_q <= refDiv_q + 4'h1;
         end
         // Swap only while both sources low
         if (wantRead != useRead_q && !readRefClk
               && !refClk_q && !recClkS)
            useRead_q <= wantRead;
         readRefClk <= useRead_q ? recClkS : refClk_q;
         // Zero until lock and data valid
         readData <= wantRead & useRead_q & rdDataS;
         // Sample on host write clock rise
         prevWrClk_q <= wrClkS;
         writeStrobe <= wrClkS & ~prevWrClk_q & wrGateS & ~attention;
         if (wrClkS && !prevWrClk_q) writeBit <= wrDataS;
      end
   end
endmodule // disk_status_config_data_port

// file: tb/disk_port_sva.sv
// Purpose: Port checks for the drive status and data port
// Assumes: Sees only the ports of the top module
// Notes: Bound from the testbench top file
`timescale 1ns/10ps
module disk_port_sva (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Watched ports
   input wire pready,
   input wire pslverr,
   input wire [31:0] prdata,
   input wire cmdFirstBit,
   input wire cmdComplete,
   input wire attention,
   input wire xferReq,
   input wire xferAck,
   input wire writeStrobe,
   input wire plLocked,
   input wire readData,
   input wire indexN,
   input wire indexGatedN,
   input wire driveSelected
);
   // One domain, so one clock and one disable for all
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ***********************************
   // Bus answers
   // ***********************************
   bus_pulse_a: assert property (pready |=> !pready)
      else $error("pready stood more than one cycle");
   bus_err_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   bus_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside an answer");
   // ***********************************
   // Link behaviour
   // ***********************************
   ack_rise_a: assert property ($rose(xferAck) |-> $past(xferReq, 3))
      else $error("acknowledge rose without request");
   ack_fall_a: assert property ($fell(xferAck) |-> !$past(xferReq, 3))
      else $error("acknowledge fell while request high");
   cc_drop_a: assert property (cmdFirstBit |=> !cmdComplete)
      else $error("complete not dropped on first bit");
   cc_lead_a: assert property ($rose(cmdComplete) && $past(attention)
      |-> $past(attention, 25))
      else $error("attention lead before complete too short");
   wr_block_a: assert property (attention [*2] |-> !writeStrobe)
      else $error("write strobe while attention");
   rd_zero_a: assert property (!plLocked [*3] |-> !readData)
      else $error("read data not zero before lock");
   idx_width_a: assert property ($fell(indexN) |=> !indexN [*8])
      else $error("index pulse too short");
   idx_gate_a: assert property (!driveSelected [*3] |-> indexGatedN)
      else $error("gated index active while deselected");
endmodule // disk_port_sva

// file: tb/host_model.sv
// Purpose: Host controller side of the serial and write link
// Assumes: Changes its pins just after rising mclk edges
// Notes: Write clock stands still while disabled
`timescale 1ns/10ps
module host_model (
   // Clock and control
   input wire mclk,
   input wire go,
   input wire wrEn,
   input wire [3:0] slow,
   // From the drive
   input wire xferAck,
   input wire configStatusData,
   // To the drive
   output reg xferReq = 1'b0,
   output reg [16:0] word = 17'h0,
   output reg done = 1'b0,
   output reg writeClk = 1'b0,
   output reg writeDataIn = 1'b0
);
   integer i;
   reg [3:0] ph = 4'h0; // Half period divider, 80 ns period
   always begin
      @(posedge mclk);
      if (go) begin
         done <= 1'b0;
         for (i = 0; i < 17; i = i + 1) begin
            xferReq <= 1'b1;
            @(posedge mclk);
            while (xferAck !== 1'b1) @(posedge mclk);
            // Bit taken at the edge that sees the acknowledge
            word <= {word[15:0], configStatusData};
            repeat (slow) @(posedge mclk);
            xferReq <= 1'b0;
            @(posedge mclk);
            while (xferAck !== 1'b0) @(posedge mclk);
         end
         done <= 1'b1;
      end
   end
   // write clock with data changing on falling edges
   always @(posedge mclk) begin
      if (!wrEn) begin
         ph <= 4'h0;
         writeClk <= 1'b0;
      end else begin
         ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
         if (ph == 4'h9) writeClk <= ~writeClk;
         if (ph == 4'h9 && writeClk) writeDataIn <= ~writeDataIn;
      end
   end
endmodule // host_model

// file: tb/tb.sv
// Purpose: Self-checking bench of the drive status and data port
// Assumes: Short index period of 2000 clocks
// Notes: Table rows first, awkward cases after
`timescale 1ns/10ps
`include "disk_port_consts.vh"
module tb;
   // Design inputs, all given at time zero
   reg mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
   reg pwrite = 1'b0, cmdFirstBit = 1'b0, cmdRequest = 1'b0;
   reg cmdFinish = 1'b0, resetAttention = 1'b0, driveSelected = 1'b1;
   reg headsOffTrackZero = 1'b0, remMediaAbsent = 1'b0;
   reg remWriteProtect = 1'b0, fixWriteProtect = 1'b0, headSelectOk = 1'b0;
   reg plLocked = 1'b0, sectoringOptionJumper = 1'b0, addrMarkDetect = 1'b0;
   reg writeGate = 1'b0, readGate = 1'b0, recoveredClk = 1'b0;
   reg rawReadData = 1'b0, writeCurrentSense = 1'b0, go = 1'b0, wrEn = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   reg [3:0] cmdOpcode = 4'h0, cmdModifier = 4'h0, slow = 4'h0;
   wire [31:0] prdata;
   wire [16:0] word;
   wire pready, pslverr, xferAck, configStatusData, attention, hostDone;
   wire cmdComplete, indexGatedN, indexN, sectorGated, sectorOut, readData;
   wire readRefClk, writeBit, writeStrobe, writeInhibit, xferReq, writeClk;
   wire writeDataIn;
   integer mismatches = 0, tests_run = 0, i, k;
   reg [31:0] d;
   reg e;
   // Rows: modifier, offset, written, read back, serial word
   localparam [59:0] ROWS [0:8] = '{60'h1_04_0400_0400_0400,
      60'h2_04_0400_0400_0000, 60'h3_08_0205_0205_0205,
      60'h4_0C_2850_2850_2850, 60'h5_10_0252_0252_0252,
      60'h6_14_1A22_0022_0022, 60'h7_18_1016_1016_1016,
      60'h8_1C_0C0D_000D_000D, 60'h9_20_0037_0007_0007};
   disk_status_config_data_port #(.INDEX_CYCLES(2000)) u_dut (.mclk,
      .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .cmdFirstBit, .cmdRequest, .cmdOpcode, .cmdModifier,
      .cmdFinish, .resetAttention, .driveSelected, .headsOffTrackZero,
      .remMediaAbsent, .remWriteProtect, .fixWriteProtect, .headSelectOk,
      .plLocked, .sectoringOptionJumper, .addrMarkDetect, .xferReq,
      .writeGate, .readGate, .writeClk, .writeDataIn, .recoveredClk,
      .rawReadData, .writeCurrentSense, .xferAck, .configStatusData,
      .attention, .cmdComplete, .indexGatedN, .indexN, .sectorGated,
      .sectorOut, .readRefClk, .readData, .writeBit, .writeStrobe,
      .writeInhibit);
   host_model u_host (.mclk, .go, .wrEn, .slow, .xferAck, .configStatusData,
      .xferReq, .word, .done(hostDone), .writeClk, .writeDataIn);
   // 250 MHz clock
   initial forever #2 mclk = ~mclk;
   // Watchdog, far beyond the expected run
   initial begin
      #240000;
      mismatches = mismatches + 1;
      stop_test;
   end
   task chk(input string nm, input [31:0] ex, input [31:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== ex) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
         end
      end
   endtask
   task stop_test;
      begin
         $display("tests %0d mismatches %0d", tests_run, mismatches);
         if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // One APB transfer, held until pready is seen
   task apb(input [7:0] a, input w, input [31:0] wd, output [31:0] rd,
         output er);
      integer n;
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= wd;
         @(posedge mclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge mclk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 99);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge mclk);
      end
   endtask
   task clr;
      begin
         resetAttention <= 1'b1;
         @(posedge mclk);
         resetAttention <= 1'b0;
         repeat (3) @(posedge mclk);
      end
   endtask
   // Request one word and fetch it over the link
   task ser(input [3:0] op, input [3:0] md, input [15:0] ex);
      integer n;
      begin
         cmdOpcode <= op;
         cmdModifier <= md;
         cmdRequest <= 1'b1;
         cmdFirstBit <= 1'b1;
         go <= 1'b1;
         @(posedge mclk);
         cmdRequest <= 1'b0;
         cmdFirstBit <= 1'b0;
         go <= 1'b0;
         n = 0;
         do begin
            @(posedge mclk);
            n = n + 1;
         end while (hostDone !== 1'b1 && n < 3000);
         chk("serial word", ex, word[16:1]);
         chk("odd parity", 1, ^word);
         n = 0;
         while (cmdComplete !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n = n + 1;
         end
         chk("complete", 1, cmdComplete);
      end
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      chk("index idle", 1, indexN);
      sys_rst <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("complete after reset", 1, cmdComplete);
      chk("power-on attention", 1, attention);
      ser(`OP_STATUS, 4'h0, 16'h0300);
      apb(`OFF_CTRL, 1'b1, 32'h2, d, e);
      clr;
      for (i = 0; i < 9; i = i + 1) begin
         slow <= i[3:0];
         apb(ROWS[i][55:48], 1'b1, {16'h0, ROWS[i][47:32]}, d, e);
         apb(ROWS[i][55:48], 1'b0, 32'h0, d, e);
         chk("readback", {16'h0, ROWS[i][31:16]}, d);
         ser(`OP_CONFIG, ROWS[i][59:56], ROWS[i][15:0]);
      end
      ser(`OP_CONFIG, `MOD_GENERAL, 16'h0000);
      apb(8'h3C, 1'b0, 32'h0, d, e);
      chk("unmapped error", 1, e);
      chk("unmapped data", 0, d);
      // State bits must not raise attention
      fixWriteProtect <= 1'b1;
      remMediaAbsent <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("state bits quiet", 0, attention);
      ser(`OP_STATUS, 4'h0, 16'h5000);
      // Every settable fault bit raises attention
      for (i = 0; i < 8; i = i + 1) if (i != 1) begin
         apb(`OFF_FAULT, 1'b1, 32'h1 << i, d, e);
         repeat (3) @(posedge mclk);
         chk("fault attention", 1, attention);
         ser(`OP_STATUS, 4'h0, 16'h5000 | (16'h1 << i));
         clr;
      end
      fixWriteProtect <= 1'b0;
      remMediaAbsent <= 1'b0;
      apb(`OFF_CTRL, 1'b1, 32'h3, d, e);
      ser(`OP_STATUS, 4'h0, 16'h0200);
      apb(`OFF_CTRL, 1'b1, 32'h2, d, e);
      clr;
      // Clean write, then write current lost
      wrEn <= 1'b1;
      headSelectOk <= 1'b1;
      repeat (30) @(posedge mclk);
      writeGate <= 1'b1;
      writeCurrentSense <= 1'b1;
      repeat (20) @(posedge mclk);
      k = 0;
      repeat (400) begin
         @(posedge mclk);
         if (writeStrobe === 1'b1) k = k + 1;
      end
      chk("write strobes", 20, k);
      writeCurrentSense <= 1'b0;
      repeat (10) @(posedge mclk);
      chk("write inhibit", 1, writeInhibit);
      k = 0;
      repeat (100) begin
         @(posedge mclk);
         if (writeStrobe === 1'b1) k = k + 1;
      end
      chk("blocked strobes", 0, k);
      ser(`OP_STATUS, 4'h0, 16'h0002);
      writeGate <= 1'b0;
      wrEn <= 1'b0;
      repeat (6) @(posedge mclk);
      clr;
      // Fault raised just before completion
      cmdFirstBit <= 1'b1;
      @(posedge mclk);
      cmdFirstBit <= 1'b0;
      apb(`OFF_FAULT, 1'b1, 32'h10, d, e);
      cmdFinish <= 1'b1;
      @(posedge mclk);
      cmdFinish <= 1'b0;
      k = 0;
      while (cmdComplete !== 1'b1 && k < 200) begin
         @(posedge mclk);
         k = k + 1;
      end
      chk("late complete", 1, cmdComplete);
      clr;
      // Soft sector mode shows address mark
      sectoringOptionJumper <= 1'b1;
      addrMarkDetect <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("mark found", 1, sectorOut);
      chk("mark gated", 1, sectorGated);
      addrMarkDetect <= 1'b0;
      sectoringOptionJumper <= 1'b0;
      // Index width and period, deselected
      driveSelected <= 1'b0;
      while (indexN !== 1'b0) @(posedge mclk);
      k = 0;
      while (indexN === 1'b0) begin
         @(posedge mclk);
         k = k + 1;
      end
      chk("index low", 250, k);
      while (indexN === 1'b1) begin
         @(posedge mclk);
         k = k + 1;
      end
      chk("index period", 2000, k);
      stop_test;
   end
endmodule // tb
bind disk_status_config_data_port disk_port_sva u_sva (.mclk, .sys_rst,
   .pready, .pslverr, .prdata, .cmdFirstBit, .cmdComplete, .attention,
   .xferReq, .xferAck, .writeStrobe, .plLocked, .readData, .indexN,
   .indexGatedN, .driveSelected);
